// >>> core/cmp_timer_defines.svh
// register offsets, field positions, reset values and counts of the compare timer
`ifndef CMP_TIMER_DEFINES_SVH
`define CMP_TIMER_DEFINES_SVH

// =====================================================================
// byte addresses on the peripheral port
`define CT_ADDR_W 3
`define CT_ADDR_CNT_HI 3'h0
`define CT_ADDR_CNT_LO 3'h1
`define CT_ADDR_CMP_HI 3'h2
`define CT_ADDR_CMP_LO 3'h3
`define CT_ADDR_CTRL 3'h4
`define CT_ADDR_STAT 3'h5

// =====================================================================
// timer_control fields
`define CT_OUT_LEVEL_HI 7
`define CT_HI_SEL_B2 6
`define CT_HI_SEL_LSB 4
`define CT_OUT_LEVEL_LO 3
`define CT_LO_SEL_LSB 0

// =====================================================================
// timer_control_status fields
`define CT_HI_OVF 7
`define CT_HI_CMF 6
`define CT_HI_OVIE 5
`define CT_HI_CCLR 4
`define CT_LO_OVF 3
`define CT_LO_CMF 2
`define CT_LO_OVIE 1
`define CT_LO_CCLR 0
`define CT_FLAG_MASK 8'hCC
`define CT_CTRL_BITS_MASK 8'h33

// =====================================================================
// reset values and fixed read values
`define CT_CNT_RST 8'h00
`define CT_CMP_RST 16'hFFFF
`define CT_CTRL_RST 8'h00
`define CT_STAT_RST 8'h00
`define CT_WO_READ 8'hFF
`define CT_BYTE_MAX 8'hFF

// =====================================================================
// clock select codes and prescaler taps
`define CT_SEL_P32 3'h4
`define CT_SEL_P16 3'h5
`define CT_SEL_P4 3'h6
`define CT_SEL_W4 3'h7
`define CT_PRE_W 5
`define CT_TAP_P32 5'h1F
`define CT_TAP_P16 5'h0F
`define CT_TAP_P4 5'h03
`define CT_WDIV_LAST 2'h3

`endif

// >>> core/cmp_timer_pkg.sv
// types shared by the compare timer modules
package cmp_timer_pkg;

  typedef logic [7:0] byte_t;

  typedef enum {
    SRC_NONE,
    SRC_P32,
    SRC_P16,
    SRC_P4,
    SRC_W4
  } clk_src_t;

endpackage

// >>> core/chan_if.sv
// carrier between the timer core and one byte counter
`timescale 1ns/10ps
interface chan_if;
  import cmp_timer_pkg::*;
  logic tick;
  logic clr;
  logic wr;
  byte_t wdata;
  byte_t cnt;
  modport ctr (input tick, input clr, input wr, input wdata, output cnt);
  modport ctl (output tick, output clr, output wr, output wdata, input cnt);
endinterface

// >>> core/byte_counter.sv
// one 8-bit up-counter with clear and cpu load
`timescale 1ns/10ps
`include "cmp_timer_defines.svh"
module byte_counter
  import cmp_timer_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // control side
  chan_if.ctr ch
);

  byte_t cnt_q;
  byte_t cnt_d;

  // cpu load wins over count and clear
  always_comb begin
    cnt_d = cnt_q;
    if (ch.wr) begin
      cnt_d = ch.wdata;
    end else if (ch.clr) begin
      // clear already carries the match tick; a 16-bit high byte gets no carry then
      cnt_d = `CT_CNT_RST;
    end else if (ch.tick) begin
      cnt_d = cnt_q + 8'h01;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_q <= `CT_CNT_RST;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign ch.cnt = cnt_q;

endmodule

// >>> core/tick_select.sv
// prescaled count ticks, watch clock synchroniser and power-mode gating
`timescale 1ns/10ps
`include "cmp_timer_defines.svh"
module tick_select
  import cmp_timer_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // watch clock and power state
  input wire logic watch_clk_i,
  input wire logic sub_mode_i,
  input wire logic halt_i,
  // clock selects
  input wire logic [2:0] sel_hi_i,
  input wire logic [2:0] sel_lo_i,
  // ticks
  output logic tick_hi_o,
  output logic tick_lo_o
);

  logic [`CT_PRE_W-1:0] pre_q;
  logic [`CT_PRE_W-1:0] pre_d;
  logic [2:0] wsync_q;
  logic [2:0] wsync_d;
  logic [1:0] wdiv_q;
  logic [1:0] wdiv_d;
  logic wrise;
  logic wtick;

  function automatic clk_src_t decode_src(input logic [2:0] sel);
    case (sel)
      `CT_SEL_P32: decode_src = SRC_P32;
      `CT_SEL_P16: decode_src = SRC_P16;
      `CT_SEL_P4: decode_src = SRC_P4;
      `CT_SEL_W4: decode_src = SRC_W4;
      default: decode_src = SRC_NONE;
    endcase
  endfunction

  // in sub modes only the watch source runs; halt stops all
  function automatic logic src_tick(input logic [2:0] sel, input logic [`CT_PRE_W-1:0] pre,
                                    input logic wt, input logic sub, input logic halt);
    logic t;
    t = 1'b0;
    case (decode_src(sel))
      SRC_P32: t = (pre == `CT_TAP_P32) && !sub;
      SRC_P16: t = ((pre & `CT_TAP_P16) == `CT_TAP_P16) && !sub;
      SRC_P4: t = ((pre & `CT_TAP_P4) == `CT_TAP_P4) && !sub;
      SRC_W4: t = wt;
      default: t = 1'b0;
    endcase
    src_tick = t && !halt;
  endfunction

  // rising watch edge counts once stage two holds the new high level while stage three still holds the old low one
  assign wrise = wsync_q[1] && !wsync_q[2];
  assign wtick = wrise && (wdiv_q == `CT_WDIV_LAST);

  always_comb begin
    pre_d = pre_q + {{(`CT_PRE_W-1){1'b0}}, 1'b1};
    wsync_d = {wsync_q[1:0], watch_clk_i};
    wdiv_d = wrise ? wdiv_q + 2'h1 : wdiv_q;
    tick_hi_o = src_tick(sel_hi_i, pre_q, wtick, sub_mode_i, halt_i);
    tick_lo_o = src_tick(sel_lo_i, pre_q, wtick, sub_mode_i, halt_i);
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pre_q <= '0;
      wsync_q <= 3'h0;
      wdiv_q <= 2'h0;
    end else begin
      pre_q <= pre_d;
      wsync_q <= wsync_d;
      wdiv_q <= wdiv_d;
    end
  end

endmodule

// >>> core/compare_timer.sv
// compare timer: one 16-bit or two 8-bit counters with compare, toggle pins and flags
`timescale 1ns/10ps
`include "cmp_timer_defines.svh"
module compare_timer
  import cmp_timer_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // watch clock and power state
  input wire logic watch_clk_i,
  input wire logic sub_mode_i,
  input wire logic standby_i,
  input wire logic module_standby_i,
  // cpu byte port
  input wire logic [`CT_ADDR_W-1:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  // toggle pins
  output logic toggle_pin_hi_o,
  output logic toggle_pin_lo_o,
  // interrupt request flags toward the controller
  output logic timer_hi_irq_flag_o,
  output logic timer_lo_irq_flag_o
);

  // =====================================================================
  // state
  byte_t ctrl_q;
  byte_t ctrl_d;
  byte_t stat_q;
  byte_t stat_d;
  byte_t armed_q;
  byte_t armed_d;
  byte_t temp_q;
  byte_t temp_d;
  byte_t rdata_q;
  byte_t rdata_d;
  logic [15:0] cmp_q;
  logic [15:0] cmp_d;
  logic pin_hi_q;
  logic pin_hi_d;
  logic pin_lo_q;
  logic pin_lo_d;
  logic irq_hi_q;
  logic irq_hi_d;
  logic irq_lo_q;
  logic irq_lo_d;

  // =====================================================================
  // decode and datapath nets
  logic mode8;
  logic wr_cnt_hi;
  logic wr_cnt_lo;
  logic wr_cmp_hi;
  logic wr_cmp_lo;
  logic wr_ctrl;
  logic wr_stat;
  logic rd_stat;
  logic rd_cnt_hi;
  logic tsel_hi;
  logic tsel_lo;
  logic tick_hi;
  logic tick_lo;
  logic eq_hi;
  logic eq_lo;
  logic match_hi;
  logic match_lo;
  logic clr_hi;
  logic clr_lo;
  logic carry_lo;
  logic ovf_hi;
  logic ovf_lo;
  logic load_hi;
  byte_t load_hi_data;
  byte_t cnt_hi;
  byte_t cnt_lo;
  logic [1:0] tick_v;
  logic [1:0] clr_v;
  logic [1:0] wr_v;
  byte_t wdata_v [2];
  byte_t cnt_v [2];

  assign mode8 = ctrl_q[`CT_HI_SEL_B2];
  assign wr_cnt_hi = wr_i && (addr_i == `CT_ADDR_CNT_HI);
  assign wr_cnt_lo = wr_i && (addr_i == `CT_ADDR_CNT_LO);
  assign wr_cmp_hi = wr_i && (addr_i == `CT_ADDR_CMP_HI);
  assign wr_cmp_lo = wr_i && (addr_i == `CT_ADDR_CMP_LO);
  assign wr_ctrl = wr_i && (addr_i == `CT_ADDR_CTRL);
  assign wr_stat = wr_i && (addr_i == `CT_ADDR_STAT);
  assign rd_stat = rd_i && (addr_i == `CT_ADDR_STAT);
  assign rd_cnt_hi = rd_i && (addr_i == `CT_ADDR_CNT_HI);

  // =====================================================================
  // tick sources
  tick_select u_tick (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .watch_clk_i(watch_clk_i),
    .sub_mode_i(sub_mode_i),
    .halt_i(standby_i || module_standby_i),
    .sel_hi_i(ctrl_q[`CT_HI_SEL_LSB+:3]),
    .sel_lo_i(ctrl_q[`CT_LO_SEL_LSB+:3]),
    .tick_hi_o(tsel_hi),
    .tick_lo_o(tsel_lo)
  );

  // =====================================================================
  // byte counters, index 1 high, 0 low
  generate
    for (genvar i = 0; i < 2; i++) begin : g_chan
      chan_if ch ();
      assign ch.tick = tick_v[i];
      assign ch.clr = clr_v[i];
      assign ch.wr = wr_v[i];
      assign ch.wdata = wdata_v[i];
      assign cnt_v[i] = ch.cnt;
      byte_counter u_cnt (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .ch(ch)
      );
    end
  endgenerate

  assign cnt_hi = cnt_v[1];
  assign cnt_lo = cnt_v[0];

  // =====================================================================
  // compare register and holding latch
  always_comb begin
    cmp_d = cmp_q;
    temp_d = temp_q;
    if (wr_cmp_hi && mode8) begin
      cmp_d[15:8] = wdata_i;
    end else if (wr_cmp_hi || (wr_cnt_hi && !mode8)) begin
      temp_d = wdata_i;
    end
    if (wr_cmp_lo) begin
      cmp_d[7:0] = wdata_i;
      if (!mode8) begin
        cmp_d[15:8] = temp_q;
      end
    end
    if (rd_cnt_hi && !mode8) begin
      temp_d = cnt_lo;
    end
  end

  // counter loads: 16-bit upper byte rides on the lower write
  assign load_hi = mode8 ? wr_cnt_hi : wr_cnt_lo;
  assign load_hi_data = mode8 ? wdata_i : temp_q;

  // =====================================================================
  // match, clear and overflow
  // a compare write is seen at once so a stale match is dropped
  assign eq_hi = (cnt_hi == cmp_d[15:8]);
  assign eq_lo = (cnt_lo == cmp_d[7:0]);
  assign tick_lo = tsel_lo;
  assign match_lo = tick_lo && eq_lo;
  assign clr_hi = match_hi && stat_q[`CT_HI_CCLR];
  assign clr_lo = mode8 ? (match_lo && stat_q[`CT_LO_CCLR]) : clr_hi;
  assign carry_lo = tick_lo && (cnt_lo == `CT_BYTE_MAX) && !clr_lo;
  assign tick_hi = mode8 ? tsel_hi : carry_lo;
  assign match_hi = mode8 ? (tsel_hi && eq_hi) : (tick_lo && eq_lo && eq_hi);
  assign ovf_lo = carry_lo && !wr_cnt_lo;
  assign ovf_hi = tick_hi && (cnt_hi == `CT_BYTE_MAX) && !clr_hi && !load_hi;

  always_comb begin
    tick_v = {tick_hi, tick_lo};
    clr_v = {clr_hi, clr_lo};
    wr_v = {load_hi, wr_cnt_lo};
    wdata_v[1] = load_hi_data;
    wdata_v[0] = wdata_i;
  end

  // =====================================================================
  // control, status flags and read arming
  always_comb begin
    ctrl_d = ctrl_q;
    stat_d = stat_q;
    armed_d = armed_q;
    if (wr_ctrl) begin
      ctrl_d = wdata_i;
    end
    if (rd_stat) begin
      armed_d = stat_q & `CT_FLAG_MASK;
    end
    if (wr_stat) begin
      stat_d = (stat_q & ~`CT_CTRL_BITS_MASK) | (wdata_i & `CT_CTRL_BITS_MASK);
      // writing 1 leaves a flag alone; 0 clears only an armed flag
      stat_d = stat_d & ~(armed_q & ~wdata_i & `CT_FLAG_MASK);
      armed_d = 8'h00;
    end
    // hardware set wins over a same-cycle clear
    if (ovf_hi) begin
      stat_d[`CT_HI_OVF] = 1'b1;
    end
    if (ovf_lo) begin
      stat_d[`CT_LO_OVF] = 1'b1;
    end
    if (match_hi) begin
      stat_d[`CT_HI_CMF] = 1'b1;
    end
    if (match_lo) begin
      stat_d[`CT_LO_CMF] = 1'b1;
    end
  end

  // =====================================================================
  // toggle pins and interrupt requests
  always_comb begin
    pin_hi_d = pin_hi_q;
    pin_lo_d = pin_lo_q;
    if (wr_ctrl) begin
      pin_hi_d = wdata_i[`CT_OUT_LEVEL_HI];
      pin_lo_d = wdata_i[`CT_OUT_LEVEL_LO];
    end else begin
      pin_hi_d = match_hi ? !pin_hi_q : pin_hi_q;
      pin_lo_d = match_lo ? !pin_lo_q : pin_lo_q;
    end
    irq_hi_d = match_hi || (ovf_hi && stat_q[`CT_HI_OVIE]);
    irq_lo_d = match_lo || (ovf_lo && stat_q[`CT_LO_OVIE]);
  end

  // =====================================================================
  // read mux
  always_comb begin
    rdata_d = rdata_q;
    if (rd_i) begin
      case (addr_i)
        `CT_ADDR_CNT_HI: rdata_d = cnt_hi;
        `CT_ADDR_CNT_LO: rdata_d = mode8 ? cnt_lo : temp_q;
        `CT_ADDR_CMP_HI: rdata_d = cmp_q[15:8];
        `CT_ADDR_CMP_LO: rdata_d = cmp_q[7:0];
        `CT_ADDR_STAT: rdata_d = stat_q;
        default: rdata_d = `CT_WO_READ;
      endcase
    end
  end

  // =====================================================================
  // registers
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_q <= `CT_CTRL_RST;
      stat_q <= `CT_STAT_RST;
      cmp_q <= `CT_CMP_RST;
      armed_q <= 8'h00;
      temp_q <= 8'h00;
      rdata_q <= 8'h00;
      pin_hi_q <= 1'b0;
      pin_lo_q <= 1'b0;
      irq_hi_q <= 1'b0;
      irq_lo_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      stat_q <= stat_d;
      cmp_q <= cmp_d;
      armed_q <= armed_d;
      temp_q <= temp_d;
      rdata_q <= rdata_d;
      pin_hi_q <= pin_hi_d;
      pin_lo_q <= pin_lo_d;
      irq_hi_q <= irq_hi_d;
      irq_lo_q <= irq_lo_d;
    end
  end

  assign rdata_o = rdata_q;
  assign toggle_pin_hi_o = pin_hi_q;
  assign toggle_pin_lo_o = pin_lo_q;
  assign timer_hi_irq_flag_o = irq_hi_q;
  assign timer_lo_irq_flag_o = irq_lo_q;

endmodule

// >>> testbench/compare_timer_checker.sv
// port assertions for the compare timer
`timescale 1ns/10ps
`include "cmp_timer_defines.svh"
module compare_timer_checker (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // power state
  input wire logic standby_i,
  // cpu byte port
  input wire logic [`CT_ADDR_W-1:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  // pins and requests
  input wire logic toggle_pin_hi_o,
  input wire logic toggle_pin_lo_o,
  input wire logic timer_hi_irq_flag_o,
  input wire logic timer_lo_irq_flag_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  // =====================================================================
  // helpers
  logic [7:0] wd_q;
  logic cw_q;
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wd_q <= 8'h00;
      cw_q <= 1'b0;
    end else begin
      wd_q <= wdata_i;
      cw_q <= wr_i && addr_i == `CT_ADDR_CTRL;
    end
  end
  sequence s_ctrl_wr;
    wr_i && addr_i == `CT_ADDR_CTRL;
  endsequence
  sequence s_halted;
    standby_i [*4];
  endsequence
  // =====================================================================
  // assertions
  AST_RESET_OUT: assert property ($fell(sys_rst_i) |-> rdata_o == 8'h00
    && !toggle_pin_hi_o && !toggle_pin_lo_o) else $error("outputs not cleared by reset");
  AST_PIN_HI_LEVEL: assert property (s_ctrl_wr |=> toggle_pin_hi_o == wd_q[7])
    else $error("high pin missed written level");
  AST_PIN_LO_LEVEL: assert property (s_ctrl_wr |=> toggle_pin_lo_o == wd_q[3])
    else $error("low pin missed written level");
  AST_CTRL_READ: assert property (rd_i && addr_i == `CT_ADDR_CTRL |=> rdata_o == 8'hFF)
    else $error("control read not all ones");
  AST_RDATA_HOLD: assert property (!rd_i |=> $stable(rdata_o))
    else $error("read data moved without a read");
  AST_HI_TOGGLE: assert property ($changed(toggle_pin_hi_o) && !cw_q |-> timer_hi_irq_flag_o)
    else $error("high pin toggled without a request");
  AST_LO_TOGGLE: assert property ($changed(toggle_pin_lo_o) && !cw_q |-> timer_lo_irq_flag_o)
    else $error("low pin toggled without a request");
  AST_IRQ_PULSE: assert property (timer_lo_irq_flag_o |=> !timer_lo_irq_flag_o)
    else $error("low request longer than one cycle");
  AST_HALT: assert property (s_halted |=> !timer_hi_irq_flag_o && !timer_lo_irq_flag_o)
    else $error("request while halted");
endmodule
bind compare_timer compare_timer_checker i_compare_timer_checker (.ref_clk_i, .sys_rst_i,
  .standby_i, .addr_i, .wr_i, .rd_i, .wdata_i, .rdata_o, .toggle_pin_hi_o, .toggle_pin_lo_o,
  .timer_hi_irq_flag_o, .timer_lo_irq_flag_o);

// >>> testbench/cpu_bus_model.sv
// cpu byte-port master for the timer registers
`timescale 1ns/10ps
`include "cmp_timer_defines.svh"
module cpu_bus_model
  import cmp_timer_pkg::*;
(
  // clock
  input wire logic ref_clk_i,
  // byte port
  output logic [`CT_ADDR_W-1:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output byte_t wdata_o,
  input wire logic [7:0] rdata_i
);
  initial begin
    addr_o = 3'h7;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h00;
  end
  task automatic wr(input logic [2:0] a, input byte_t d);
    @(posedge ref_clk_i);
    #1;
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(posedge ref_clk_i);
    #1;
    wr_o = 1'b0;
    wdata_o = ~d;
  endtask
  task automatic rd(input logic [2:0] a, output byte_t d);
    @(posedge ref_clk_i);
    #1;
    addr_o = a;
    rd_o = 1'b1;
    @(posedge ref_clk_i);
    #1;
    rd_o = 1'b0;
    d = rdata_i;
  endtask
  // upper byte first, one idle cycle apart
  task automatic wr_word(input logic [2:0] a, input logic [15:0] w);
    wr(a, w[15:8]);
    wr(a + 3'h1, w[7:0]);
  endtask
endmodule

// >>> testbench/compare_timer_bench.sv
// self-checking bench for the compare timer
`timescale 1ns/10ps
`include "cmp_timer_defines.svh"
module compare_timer_bench
  import cmp_timer_pkg::*;
();
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic watch_clk_i = 1'b0;
  logic sub_mode_i = 1'b0;
  logic standby_i = 1'b0;
  logic module_standby_i = 1'b0;
  logic [2:0] addr;
  logic wr;
  logic rd;
  byte_t wdata;
  logic [7:0] rdata;
  logic pin_hi;
  logic pin_lo;
  logic irq_lo;
  logic irq_hi;
  byte_t v;
  int fail_count = 0;
  int n_tests = 0;
  localparam logic [2:0] a_chi = `CT_ADDR_CNT_HI;
  localparam logic [2:0] a_clo = `CT_ADDR_CNT_LO;
  localparam logic [2:0] a_mhi = `CT_ADDR_CMP_HI;
  localparam logic [2:0] a_mlo = `CT_ADDR_CMP_LO;
  localparam logic [2:0] a_ct = `CT_ADDR_CTRL;
  localparam logic [2:0] a_st = `CT_ADDR_STAT;
  always #10 ref_clk_i = ~ref_clk_i;
  always #500 watch_clk_i = ~watch_clk_i;
  compare_timer i_compare_timer (.ref_clk_i, .sys_rst_i, .watch_clk_i, .sub_mode_i,
    .standby_i, .module_standby_i, .addr_i(addr), .wr_i(wr), .rd_i(rd),
    .wdata_i(wdata), .rdata_o(rdata), .toggle_pin_hi_o(pin_hi), .toggle_pin_lo_o(pin_lo),
    .timer_hi_irq_flag_o(irq_hi), .timer_lo_irq_flag_o(irq_lo));
  cpu_bus_model i_cpu_bus_model (.ref_clk_i, .addr_o(addr), .wr_o(wr), .rd_o(rd),
    .wdata_o(wdata), .rdata_i(rdata));
  task automatic chk(input string what, input byte_t exp, input byte_t got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rchk(input logic [2:0] a, input byte_t exp, input string what);
    byte_t d;
    i_cpu_bus_model.rd(a, d);
    chk(what, exp, d);
  endtask
  task automatic w(input logic [2:0] a, input byte_t d);
    i_cpu_bus_model.wr(a, d);
  endtask
  task automatic wait_lo(input int lim, input logic exp, input logic sel_hi = 1'b0);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < lim && !hit; i++) begin
      @(posedge ref_clk_i);
      #1;
      hit = ((sel_hi ? irq_hi : irq_lo) === 1'b1);
    end
    chk(sel_hi ? "hi request" : "lo request", {7'h00, exp}, {7'h00, hit});
  endtask
  task automatic do_reset();
    @(posedge ref_clk_i);
    #1;
    sys_rst_i = 1'b1;
    repeat (5) @(posedge ref_clk_i);
    #1;
    sys_rst_i = 1'b0;
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // watchdog far beyond the fewer than 1100 cycles the tests need
  initial begin
    #1000000;
    fail_count++;
    stop_test();
  end
  initial begin
    do_reset();
    rchk(a_chi, 8'h00, "count hi");
    rchk(a_clo, 8'h00, "count lo");
    rchk(a_mhi, 8'hFF, "compare hi");
    rchk(a_mlo, 8'hFF, "compare lo");
    rchk(a_st, 8'h00, "status");
    rchk(a_ct, 8'hFF, "control");
    i_cpu_bus_model.wr_word(a_chi, 16'hAA55);
    i_cpu_bus_model.wr_word(a_mhi, 16'h1234);
    rchk(a_chi, 8'hAA, "count hi");
    rchk(a_clo, 8'h55, "count lo");
    rchk(a_mlo, 8'h34, "compare lo");
    rchk(a_mhi, 8'h12, "compare hi");
    // 8-bit low match with clear
    do_reset();
    i_cpu_bus_model.wr_word(a_mhi, 16'hFF03);
    w(a_st, 8'h01);
    w(a_ct, 8'h4E);
    chk("pin lo", 8'h01, {7'h00, pin_lo});
    wait_lo(40, 1'b1);
    chk("pin lo", 8'h00, {7'h00, pin_lo});
    i_cpu_bus_model.rd(a_clo, v);
    chk("count lo bound", 8'h01, {7'h00, v <= 8'h03});
    w(a_ct, 8'h48);
    rchk(a_st, 8'h05, "status");
    w(a_st, 8'h05);
    rchk(a_st, 8'h05, "status");
    w(a_st, 8'h01);
    rchk(a_st, 8'h01, "status");
    // 8-bit low overflow, match leaving FF
    do_reset();
    w(a_st, 8'h02);
    i_cpu_bus_model.wr_word(a_chi, 16'h00FE);
    w(a_ct, 8'h46);
    wait_lo(40, 1'b1);
    rchk(a_st, 8'h0E, "status");
    // 16-bit cascade
    do_reset();
    w(a_st, 8'h02);
    i_cpu_bus_model.wr_word(a_chi, 16'h00FE);
    w(a_ct, 8'h06);
    wait_lo(40, 1'b1);
    w(a_ct, 8'h00);
    rchk(a_chi, 8'h01, "count hi");
    rchk(a_st, 8'h0E, "status");
    // sub mode counts on the watch source only
    do_reset();
    sub_mode_i = 1'b1;
    w(a_st, 8'h02);
    i_cpu_bus_model.wr_word(a_chi, 16'h00FF);
    w(a_ct, 8'h46);
    wait_lo(100, 1'b0);
    w(a_ct, 8'h47);
    wait_lo(600, 1'b1);
    sub_mode_i = 1'b0;
    // 16-bit full match clears the whole counter
    do_reset();
    w(a_st, 8'h10);
    i_cpu_bus_model.wr_word(a_mhi, 16'h0102);
    i_cpu_bus_model.wr_word(a_chi, 16'h00FE);
    w(a_ct, 8'h06);
    wait_lo(40, 1'b1, 1'b1);
    chk("pin hi", 8'h01, {7'h00, pin_hi});
    rchk(a_st, 8'h5C, "status");
    rchk(a_chi, 8'h00, "count hi");
    rchk(a_clo, 8'h00, "count lo");
    // standby halts
    do_reset();
    w(a_ct, 8'h46);
    standby_i = 1'b1;
    w(a_clo, 8'h10);
    repeat (40) @(posedge ref_clk_i);
    rchk(a_clo, 8'h10, "count lo");
    standby_i = 1'b0;
    module_standby_i = 1'b1;
    w(a_clo, 8'h20);
    repeat (40) @(posedge ref_clk_i);
    rchk(a_clo, 8'h20, "count lo");
    module_standby_i = 1'b0;
    stop_test();
  end
endmodule
